// ==== dv/bcsr_monitor.sv ====
`timescale 1ns/1ps
module bcsr_monitor (
	// Clock, reset
	input wire logic       CLK,
	input wire logic       RST_N,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	// Side signals
	input wire logic       NVM_LOAD_START,
	input wire logic       PROTECTION_IRQ_PENDING,
	input wire logic       INPUT_BIT_MAP_SELECT,
	input wire logic       RECEIVER_PIXEL_MODE,
	input wire logic       RECEIVER_PORT_SWAP,
	input wire logic       RX_USE_SECONDARY,
	input wire logic       RX_PORTS_EXCHANGED,
	input wire logic       AUDIO_ENABLE,
	input wire logic       TDM_PACK_ENABLE,
	input wire logic       TDM_SPLIT_ENABLE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// -------------------
	// Checks
	// -------------------
	property p_idle; !REG_RD |=> REG_RDATA == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_map; REG_WR && REG_ADDR == 8'h4F |=> INPUT_BIT_MAP_SELECT == $past(REG_WDATA[7]);
	endproperty
	a_map: assert property (p_map) else $error("map select wrong");
	property p_swap; REG_WR && REG_ADDR == 8'h4F |=> RECEIVER_PORT_SWAP == $past(REG_WDATA[5]);
	endproperty
	a_swap: assert property (p_swap) else $error("port swap wrong");
	property p_rx; RX_USE_SECONDARY == (RECEIVER_PORT_SWAP && RECEIVER_PIXEL_MODE)
		&& RX_PORTS_EXCHANGED == (RECEIVER_PORT_SWAP && !RECEIVER_PIXEL_MODE); endproperty
	a_rx: assert property (p_rx) else $error("port routing wrong");
	property p_aud; REG_WR && REG_ADDR == 8'h54 |=> AUDIO_ENABLE == $past(REG_WDATA[1])
		&& TDM_PACK_ENABLE == ($past(REG_WDATA[2]) && $past(REG_WDATA[1])); endproperty
	a_aud: assert property (p_aud) else $error("audio enables wrong");
	property p_split; REG_WR && REG_ADDR == 8'h55 |=> TDM_SPLIT_ENABLE == $past(REG_WDATA[7]);
	endproperty
	a_split: assert property (p_split) else $error("split enable wrong");
	property p_irq; REG_RD && REG_ADDR == 8'h50 |=> REG_RDATA[5] == $past(PROTECTION_IRQ_PENDING);
	endproperty
	a_irq: assert property (p_irq) else $error("irq status wrong");
	property p_order; REG_RD && REG_ADDR == 8'h50 ##1 REG_RDATA[4] |-> REG_RDATA[2]; endproperty
	a_order: assert property (p_order) else $error("init before config");
	property p_rsv; REG_RD && REG_ADDR == 8'h4F |=> REG_RDATA[4:2] == 3'h0 && !REG_RDATA[0];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved ctrl bits set");
	property p_pulse; NVM_LOAD_START |=> !NVM_LOAD_START; endproperty
	a_pulse: assert property (p_pulse) else $error("load start too long");
	// Main scenarios
	c_init: cover property (REG_WR && REG_ADDR == 8'h4F && REG_WDATA[1]);
	c_irq: cover property (REG_RD && REG_ADDR == 8'h50 && PROTECTION_IRQ_PENDING);
	c_exch: cover property (RX_PORTS_EXCHANGED);
endmodule // bcsr_monitor

bind bcsr_top bcsr_monitor i_bcsr_monitor (.CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR,
	.REG_RD, .REG_RDATA, .NVM_LOAD_START, .PROTECTION_IRQ_PENDING, .INPUT_BIT_MAP_SELECT,
	.RECEIVER_PIXEL_MODE, .RECEIVER_PORT_SWAP, .RX_USE_SECONDARY, .RX_PORTS_EXCHANGED,
	.AUDIO_ENABLE, .TDM_PACK_ENABLE, .TDM_SPLIT_ENABLE);

// ==== dv/tb_bcsr_top.sv ====
`timescale 1ns/1ps
module tb_bcsr_top;
	logic CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, NVM_BYTE = 8'h00, REG_RDATA;
	logic NVM_LOAD_DONE = 1'b0, NVM_BYTE_VALID = 1'b0, IRQ = 1'b0;
	logic MODE_STRAP_A = 1'b1, MODE_STRAP_B = 1'b0;
	logic START, MAP, MODE, SWAP, SEC, EXCH, AUD, PACK, SPLIT;
	int n_fail = 0, tests_run = 0, cyc = 0, n_start = 0, n_seen = 0;
	bcsr_top #(.CKSUM_BYTES(4)) i_bcsr_top (.CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR,
		.REG_RD, .REG_RDATA, .MODE_STRAP_A, .MODE_STRAP_B,
		.NVM_LOAD_START(START), .NVM_LOAD_DONE, .NVM_BYTE_VALID, .NVM_BYTE,
		.PROTECTION_IRQ_PENDING(IRQ), .INPUT_BIT_MAP_SELECT(MAP),
		.RECEIVER_PIXEL_MODE(MODE), .RECEIVER_PORT_SWAP(SWAP), .RX_USE_SECONDARY(SEC),
		.RX_PORTS_EXCHANGED(EXCH), .AUDIO_ENABLE(AUD), .TDM_PACK_ENABLE(PACK),
		.TDM_SPLIT_ENABLE(SPLIT));
	// -------------------
	// Clock, timeout
	// -------------------
	always #2.5 CLK = ~CLK;
	// Count loader start pulses, even those that end before a reload task runs
	always @(negedge CLK) begin
		if (START === 1'b1) begin
			n_start++;
		end
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			summarize();
		end
	end
	// -------------------
	// Tasks
	// -------------------
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
		@(negedge CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		@(negedge CLK);
		chk("rdata", REG_RDATA, e);
	endtask
	// Loader answer: done, then four checksum bytes
	task automatic reload(input logic [7:0] b0);
		int i;
		i = 0;
		while (n_start == n_seen && i < 40) begin
			@(negedge CLK);
			i++;
		end
		chk("start", 8'(n_start - n_seen), 8'h01);
		n_seen = n_start;
		@(posedge CLK);
		NVM_LOAD_DONE <= 1'b1;
		@(posedge CLK);
		NVM_LOAD_DONE <= 1'b0;
		NVM_BYTE_VALID <= 1'b1;
		NVM_BYTE <= b0;
		repeat (3) @(posedge CLK) NVM_BYTE <= 8'h01;
		@(posedge CLK);
		NVM_BYTE_VALID <= 1'b0;
	endtask
	task automatic summarize();
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// -------------------
	// Main sequence
	// -------------------
	initial begin
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		reload(8'hFD);
		rd(8'h4F, 8'h40);
		rd(8'h50, 8'h16);
		rd(8'h54, 8'h02);
		rd(8'h55, 8'h00);
		rd(8'h51, 8'h00);
		chk("map", {7'h00, MAP}, 8'h00);
		wr(8'h4F, 8'hFF);
		rd(8'h4F, 8'hE2);
		reload(8'h00);
		rd(8'h4F, 8'hE0);
		rd(8'h50, 8'h14);
		chk("rx", {3'h0, MAP, MODE, SWAP, SEC, EXCH}, 8'h1E);
		wr(8'h4F, 8'hA0);
		chk("rx", {3'h0, MAP, MODE, SWAP, SEC, EXCH}, 8'h15);
		wr(8'h54, 8'hFF);
		rd(8'h54, 8'h06);
		chk("aud", {6'h00, AUD, PACK}, 8'h03);
		wr(8'h54, 8'h04);
		chk("aud", {6'h00, AUD, PACK}, 8'h00);
		wr(8'h55, 8'hFF);
		rd(8'h55, 8'h80);
		chk("split", {7'h00, SPLIT}, 8'h01);
		@(posedge CLK) IRQ <= 1'b1;
		rd(8'h50, 8'h34);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'h34);
		// Second reset with the other strap pattern
		@(posedge CLK);
		RST_N <= 1'b0;
		IRQ <= 1'b0;
		MODE_STRAP_A <= 1'b0;
		MODE_STRAP_B <= 1'b1;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		rd(8'h50, 8'h02);
		reload(8'hFD);
		rd(8'h4F, 8'h80);
		chk("map", {7'h00, MAP}, 8'h01);
		chk("aud", {6'h00, AUD, PACK}, 8'h02);
		summarize();
	end
endmodule // tb_bcsr_top

// ==== verilog/bcsr_consts.svh ====
`ifndef BCSR_CONSTS_SVH
`define BCSR_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCSR_ADDR_W          8
`define BCSR_DATA_W          8
`define BCSR_OFF_CTRL        8'h4F
`define BCSR_OFF_STATUS      8'h50
`define BCSR_OFF_CONFIG      8'h54
`define BCSR_OFF_AUDIO       8'h55

// ----------------------------------------
// Bridge control fields
// ----------------------------------------
`define BCSR_CTRL_MAP_BIT    7
`define BCSR_CTRL_MODE_BIT   6
`define BCSR_CTRL_SWAP_BIT   5
`define BCSR_CTRL_INIT_BIT   1
`define BCSR_CTRL_SWAP_RST   1'h0
`define BCSR_CTRL_INIT_RST   1'h0

// ----------------------------------------
// Bridge status fields
// ----------------------------------------
`define BCSR_STS_IRQ_BIT     5
`define BCSR_STS_INIT_BIT    4
`define BCSR_STS_CFG_BIT     2
`define BCSR_STS_SUM_BIT     1
`define BCSR_STS_INIT_RST    1'h0
`define BCSR_STS_CFG_RST     1'h0
`define BCSR_STS_SUM_RST     1'h1

// ----------------------------------------
// Bridge config and audio fields
// ----------------------------------------
`define BCSR_CFG_TDM_BIT     2
`define BCSR_CFG_AUD_BIT     1
`define BCSR_CFG_TDM_RST     1'h0
`define BCSR_CFG_AUD_RST     1'h1
`define BCSR_AUD_SPLIT_BIT   7
`define BCSR_AUD_SPLIT_RST   1'h0

// ----------------------------------------
// Timing and sizes
// ----------------------------------------
`define BCSR_CKSUM_BYTES     128
`define BCSR_STRAP_SETTLE    3

`endif

// ==== verilog/bcsr_pkg.sv ====
// ----------------------------------------
// Types shared by the register bank
// ----------------------------------------
package bcsr_pkg;

	// Configuration reload sequencer
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_LOAD,
		SEQ_SUM
	} bcsr_seq_type;

	// Byte of the register port
	typedef logic [7:0] bcsr_byte_type;

endpackage

// ==== verilog/bcsr_top.sv ====
// Operation
// - Control bit 7 selects receiver bit mapping
// - Mapping bit loads from strap B at reset
// - Control bit 6 selects single or dual pixel
// - Pixel mode bit loads from strap A
// - Control bit 5 swaps receiver ports
// - Control bit 1 reloads config, self-clears
// - Status bit 5 shows pending protection interrupt
// - Status bit 4 shows initialization done
// - Status bit 2 shows configuration done first
// - Status bit 1 shows checksum pass
// - Config bit 2 enables audio TDM packing
// - Config bit 1 enables pin audio source
// - Audio bit 7 enables TDM splitting
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "bcsr_consts.svh"

module bcsr_top #(
	parameter int CKSUM_BYTES = `BCSR_CKSUM_BYTES
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST_N,
	// Register port
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic      [7:0] REG_RDATA,
	// Mode strap pins
	input  wire logic       MODE_STRAP_A,
	input  wire logic       MODE_STRAP_B,
	// Non-volatile memory loader
	output logic            NVM_LOAD_START,
	input  wire logic       NVM_LOAD_DONE,
	input  wire logic       NVM_BYTE_VALID,
	input  wire logic [7:0] NVM_BYTE,
	// Protection transmitter interrupt
	input  wire logic       PROTECTION_IRQ_PENDING,
	// Receiver controls
	output logic            INPUT_BIT_MAP_SELECT,
	output logic            RECEIVER_PIXEL_MODE,
	output logic            RECEIVER_PORT_SWAP,
	output logic            RX_USE_SECONDARY,
	output logic            RX_PORTS_EXCHANGED,
	// Audio controls
	output logic            AUDIO_ENABLE,
	output logic            TDM_PACK_ENABLE,
	output logic            TDM_SPLIT_ENABLE
);

	// ----------------------------------------
	// Decode helper
	// ----------------------------------------

	// Strobe hits one register offset
	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] off,
		input logic       stb
	);
		reg_hit = stb && (addr == off);
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_r;
	logic rst_sync_r;
	logic rst_n;

	// Two-flop release of the asynchronous reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign rst_n = rst_sync_r;

	// ----------------------------------------
	// Strap synchronisers
	// ----------------------------------------
	logic [1:0] strap_pin;
	logic [1:0] strap_meta_r;
	logic [1:0] strap_sync_r;

	assign strap_pin = {MODE_STRAP_B, MODE_STRAP_A};

	// Two flops per strap pin
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_strap
			always_ff @(posedge CLK or negedge rst_n) begin
				if (!rst_n) begin
					strap_meta_r[gi] <= 1'b0;
					strap_sync_r[gi] <= 1'b0;
				end else begin
					strap_meta_r[gi] <= strap_pin[gi];
					strap_sync_r[gi] <= strap_meta_r[gi];
				end
			end
		end
	endgenerate

	// Settle counter; straps are latched once after release
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	logic       strap_take;
	logic       strap_done_r;

	assign strap_take = !strap_done_r && (settle_r == 2'(`BCSR_STRAP_SETTLE));
	assign settle_nxt = strap_done_r ? settle_r : settle_r + 2'h1;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			settle_r     <= 2'h0;
			strap_done_r <= 1'b0;
		end else begin
			settle_r     <= settle_nxt;
			strap_done_r <= strap_done_r | strap_take;
		end
	end

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_aud;

	assign wr_ctrl = reg_hit(REG_ADDR, `BCSR_OFF_CTRL, REG_WR);
	assign wr_cfg  = reg_hit(REG_ADDR, `BCSR_OFF_CONFIG, REG_WR);
	assign wr_aud  = reg_hit(REG_ADDR, `BCSR_OFF_AUDIO, REG_WR);

	// ----------------------------------------
	// Bridge control register
	// ----------------------------------------
	logic map_sel_r;
	logic map_sel_nxt;
	logic pix_mode_r;
	logic pix_mode_nxt;
	logic swap_r;
	logic swap_nxt;
	logic init_req_r;
	logic init_req_nxt;
	logic init_set;
	logic seq_finish;

	// Strap wins only in its one capture cycle
	assign map_sel_nxt  = strap_take ? strap_sync_r[1] :
		(wr_ctrl ? REG_WDATA[`BCSR_CTRL_MAP_BIT] : map_sel_r);
	assign pix_mode_nxt = strap_take ? strap_sync_r[0] :
		(wr_ctrl ? REG_WDATA[`BCSR_CTRL_MODE_BIT] : pix_mode_r);
	assign swap_nxt     = wr_ctrl ? REG_WDATA[`BCSR_CTRL_SWAP_BIT] : swap_r;

	// Software set beats the hardware clear
	assign init_set     = wr_ctrl && REG_WDATA[`BCSR_CTRL_INIT_BIT];
	assign init_req_nxt = init_set ? 1'b1 : (seq_finish ? 1'b0 : init_req_r);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			map_sel_r  <= 1'b0;
			pix_mode_r <= 1'b0;
			swap_r     <= `BCSR_CTRL_SWAP_RST;
			init_req_r <= `BCSR_CTRL_INIT_RST;
		end else begin
			map_sel_r  <= map_sel_nxt;
			pix_mode_r <= pix_mode_nxt;
			swap_r     <= swap_nxt;
			init_req_r <= init_req_nxt;
		end
	end

	// ----------------------------------------
	// Bridge config and audio registers
	// ----------------------------------------
	logic tdm_pack_r;
	logic aud_mode_r;
	logic tdm_split_r;

	// Only documented bits are stored
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tdm_pack_r  <= `BCSR_CFG_TDM_RST;
			aud_mode_r  <= `BCSR_CFG_AUD_RST;
			tdm_split_r <= `BCSR_AUD_SPLIT_RST;
		end else begin
			if (wr_cfg) begin
				tdm_pack_r <= REG_WDATA[`BCSR_CFG_TDM_BIT];
				aud_mode_r <= REG_WDATA[`BCSR_CFG_AUD_BIT];
			end
			if (wr_aud) begin
				tdm_split_r <= REG_WDATA[`BCSR_AUD_SPLIT_BIT];
			end
		end
	end

	// ----------------------------------------
	// Reload sequencer
	// ----------------------------------------
	bcsr_pkg::bcsr_seq_type seq_r;
	bcsr_pkg::bcsr_seq_type seq_nxt;
	logic       boot_r;
	logic       seq_start;
	logic       sum_last;
	logic [7:0] sum_r;
	logic [7:0] sum_nxt;
	logic [7:0] sum_add;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic       cfg_done_r;
	logic       init_done_r;
	logic       cksum_ok_r;

	// Power-up load once straps are latched, or a software reload
	assign seq_start  = (seq_r == bcsr_pkg::SEQ_IDLE) && (boot_r || init_req_r);
	assign sum_add    = sum_r + NVM_BYTE;
	assign sum_last   = NVM_BYTE_VALID && (cnt_r == 8'(CKSUM_BYTES - 1));
	assign seq_finish = (seq_r == bcsr_pkg::SEQ_SUM) && sum_last;

	// Next state of the sequencer
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			bcsr_pkg::SEQ_IDLE: begin
				if (seq_start) begin
					seq_nxt = bcsr_pkg::SEQ_LOAD;
				end
			end
			bcsr_pkg::SEQ_LOAD: begin
				if (NVM_LOAD_DONE) begin
					seq_nxt = bcsr_pkg::SEQ_SUM;
				end
			end
			bcsr_pkg::SEQ_SUM: begin
				if (sum_last) begin
					seq_nxt = bcsr_pkg::SEQ_IDLE;
				end
			end
			default: begin
				seq_nxt = bcsr_pkg::SEQ_IDLE;
			end
		endcase
	end

	// Byte counter and running sum over the checksum area
	assign cnt_nxt = (seq_r != bcsr_pkg::SEQ_SUM) ? 8'h00 :
		(NVM_BYTE_VALID ? cnt_r + 8'h01 : cnt_r);
	assign sum_nxt = (seq_r != bcsr_pkg::SEQ_SUM) ? 8'h00 :
		(NVM_BYTE_VALID ? sum_add : sum_r);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			seq_r <= bcsr_pkg::SEQ_IDLE;
			cnt_r <= 8'h00;
			sum_r <= 8'h00;
		end else begin
			seq_r <= seq_nxt;
			cnt_r <= cnt_nxt;
			sum_r <= sum_nxt;
		end
	end

	// Boot request armed by strap capture
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			boot_r <= 1'b0;
		end else if (strap_take) begin
			boot_r <= 1'b1;
		end else if (seq_start) begin
			boot_r <= 1'b0;
		end
	end

	// Status flags: configuration first, then initialization
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg_done_r  <= `BCSR_STS_CFG_RST;
			init_done_r <= `BCSR_STS_INIT_RST;
			cksum_ok_r  <= `BCSR_STS_SUM_RST;
		end else begin
			if (seq_start) begin
				cfg_done_r  <= 1'b0;
				init_done_r <= 1'b0;
			end
			if ((seq_r == bcsr_pkg::SEQ_LOAD) && NVM_LOAD_DONE) begin
				cfg_done_r <= 1'b1;
			end
			if (seq_finish) begin
				init_done_r <= 1'b1;
				cksum_ok_r  <= (sum_add == 8'h00);
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] ctrl_view;
	logic [7:0] sts_view;
	logic [7:0] cfg_view;
	logic [7:0] aud_view;
	logic [7:0] rd_mux;
	logic [7:0] rdata_r;
	logic       rd_hit;

	// Reserved positions are tied to zero
	assign ctrl_view = {map_sel_r, pix_mode_r, swap_r, 3'h0, init_req_r, 1'b0};
	assign sts_view  = {2'h0, PROTECTION_IRQ_PENDING, init_done_r, 1'b0,
		cfg_done_r, cksum_ok_r, 1'b0};
	assign cfg_view  = {5'h00, tdm_pack_r, aud_mode_r, 1'b0};
	assign aud_view  = {tdm_split_r, 7'h00};

	assign rd_hit = REG_RD;
	assign rd_mux =
		reg_hit(REG_ADDR, `BCSR_OFF_CTRL, rd_hit)   ? ctrl_view :
		reg_hit(REG_ADDR, `BCSR_OFF_STATUS, rd_hit) ? sts_view  :
		reg_hit(REG_ADDR, `BCSR_OFF_CONFIG, rd_hit) ? cfg_view  :
		reg_hit(REG_ADDR, `BCSR_OFF_AUDIO, rd_hit)  ? aud_view  : 8'h00;

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rd_mux;
		end
	end

	assign REG_RDATA = rdata_r;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic start_r;

	// Loader start pulse, one cycle
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= 1'b0;
		end else begin
			start_r <= seq_start;
		end
	end

	assign NVM_LOAD_START       = start_r;
	assign INPUT_BIT_MAP_SELECT = map_sel_r;
	assign RECEIVER_PIXEL_MODE  = pix_mode_r;
	assign RECEIVER_PORT_SWAP   = swap_r;
	assign RX_USE_SECONDARY     = swap_r && pix_mode_r;
	assign RX_PORTS_EXCHANGED   = swap_r && !pix_mode_r;
	assign AUDIO_ENABLE         = aud_mode_r;
	assign TDM_PACK_ENABLE      = tdm_pack_r && aud_mode_r;
	assign TDM_SPLIT_ENABLE     = tdm_split_r;

endmodule // bcsr_top
